// ==== design/clock_source_startup_select.sv ====
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "clk_startup_defines.svh"

module clock_source_startup_select #(
  parameter int unsigned SLOW_DLY_TICKS = `US_TO_TICKS(`DLY_SLOW_US) // long delay, wdt ticks
) (
  input wire logic clk_sys_in, // 125 MHz system clock
  input wire logic srst_in, // synchronous reset, high
  input wire logic [3:0] clock_source_select_fuses_in, // source select fuses
  input wire logic [1:0] startup_time_fuses_in, // start-up time fuses
  input wire logic divide_by_eight_fuse_in, // high = programmed
  input wire logic [7:0] cal_byte_in, // factory calibration byte
  input wire logic external_clock_input_in, // external clock pin
  input wire logic rc_osc_clk_in, // internal RC oscillator
  input wire logic osc128_clk_in, // 128 kHz oscillator
  input wire logic timer_osc_pin_one_in, // watch crystal oscillator
  input wire logic wdt_osc_clk_in, // watchdog oscillator
  input wire logic sleep_req_in, // core enters power-down/save
  input wire logic wake_req_in, // wake event
  input wire logic [11:0] paddr_in, // APB address
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error on unmapped address
  output logic core_clk_en_out, // core clock enable pulse
  output logic core_rst_out, // core held in reset
  output logic wdt_clk_en_out, // watchdog tick pulse
  output logic [7:0] rc_trim_out, // trim to RC oscillator
  output clk_startup_pkg::source_t active_source_out // selected source
);
  import clk_startup_pkg::*;

  // ----------------------------------------
  // delay targets in watchdog ticks
  // ----------------------------------------
  localparam logic [15:0] LF_FAST_TICKS = 16'(`US_TO_TICKS(`DLY_LF_FAST_US));
  localparam logic [15:0] FAST_TICKS = 16'(`US_TO_TICKS(`DLY_FAST_US));
  localparam logic [15:0] SLOW_TICKS = 16'(SLOW_DLY_TICKS);

  // ----------------------------------------
  // state
  // ----------------------------------------
  state_t state_q; // sequencer state
  state_t state_d; // next sequencer state
  logic [15:0] cnt_q; // cycle or tick counter
  logic [15:0] cnt_d; // next counter value
  logic [2:0] div_q; // divide-by-eight phase
  logic [2:0] div_d; // next phase
  logic [3:0] cks_q; // fuses caught at reset
  logic [1:0] stime_q; // start-up fuses caught at reset
  logic div8_q; // divide fuse caught at reset
  logic core_rst_q; // core reset output
  logic clk_en_q; // core clock enable output
  logic wdt_en_q; // watchdog tick output
  logic [7:0] rc_trim_q; // trim register
  source_t src_q; // active source output
  logic [31:0] prdata_q; // read data
  logic pready_q; // ready, one wait state
  logic pslverr_q; // error flag
  logic [`NUM_PINS-1:0] rise; // settled oscillator edges

  // ----------------------------------------
  // oscillator edge detection
  // ----------------------------------------
  // every oscillator is asynchronous to clk_sys, so each passes three flops
  osc_edge_sync #(
    .N(`NUM_PINS)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .pins_in({wdt_osc_clk_in, timer_osc_pin_one_in, osc128_clk_in,
              rc_osc_clk_in, external_clock_input_in}),
    .rise_out(rise)
  );

  // ----------------------------------------
  // source decode
  // ----------------------------------------
  wire is_ext = (cks_q == `CKS_EXT);
  wire is_rc = (cks_q == `CKS_RC);
  wire is_o128 = (cks_q == `CKS_OSC128);
  // watch crystal: the whole 01xx family, low bit picks the wake length
  wire is_lf = (cks_q[3:2] == `CKS_LF_TOP);
  wire src_valid = is_ext | is_rc | is_o128 | is_lf;
  wire wdt_edge = rise[`PIN_WDT];
  // only the selected source's edges form src_edge, which drives the reset and wake counts
  wire src_edge = (is_ext & rise[`PIN_EXT]) | (is_rc & rise[`PIN_RC])
                | (is_o128 & rise[`PIN_OSC128]) | (is_lf & rise[`PIN_LF]);
  wire source_t src_d = is_ext ? SRC_EXT : is_rc ? SRC_RC : is_o128 ? SRC_OSC128
                      : is_lf ? SRC_LFXTAL : SRC_NONE;

  // ----------------------------------------
  // start-up targets from the fuses
  // ----------------------------------------
  // watch crystal wakes on 1K or 32K cycles, every other source on 6
  wire [15:0] wake_tgt = is_lf ? (cks_q[0] ? `WAKE_CK_LF32K : `WAKE_CK_LF1K)
                       : `WAKE_CK_SHORT;
  // reserved code 11 falls back to the longest delay, the safe side
  wire [15:0] ms_tgt = (stime_q == `STIME_SHORT) ? 16'h0000
                     : (stime_q == `STIME_FAST) ? (is_lf ? LF_FAST_TICKS : FAST_TICKS)
                     : SLOW_TICKS;
  wire ck_last = (cnt_q == `RESET_CK - 16'h0001);
  wire ms_last = (cnt_q == ms_tgt - 16'h0001);
  wire wake_last = (cnt_q == wake_tgt - 16'h0001);

  // ----------------------------------------
  // start-up sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_POR_CK: begin
        // fixed 14 source cycles after reset; an invalid code never counts
        if (src_edge) begin
          cnt_d = ck_last ? 16'h0000 : cnt_q + 16'h0001;
          if (ck_last) begin
            state_d = (ms_tgt == 16'h0000) ? ST_RUN : ST_POR_MS;
          end
        end
      end
      ST_POR_MS: begin
        // time-out runs on the watchdog oscillator, whatever the source
        if (wdt_edge) begin
          cnt_d = ms_last ? 16'h0000 : cnt_q + 16'h0001;
          if (ms_last) begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        // sleep stops the core clock until the wake count after a wake event ends
        if (sleep_req_in) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_req_in) begin
          state_d = ST_WAKE;
          cnt_d = 16'h0000;
        end
      end
      ST_WAKE: begin
        // count the selected source until it is trusted again
        if (src_edge) begin
          cnt_d = wake_last ? 16'h0000 : cnt_q + 16'h0001;
          if (wake_last) begin
            state_d = ST_RUN;
          end
        end
      end
      default: begin
        state_d = ST_POR_CK;
        cnt_d = 16'h0000;
      end
    endcase
  end

  wire run = (state_q == ST_RUN);
  wire rst_d = (state_d == ST_POR_CK) | (state_d == ST_POR_MS);
  // one core tick per source edge, or per eighth edge with the fuse set
  assign div_d = (run & src_edge) ? div_q + 3'h1 : (run ? div_q : 3'h0);
  wire clk_en_d = run & src_edge & (~div8_q | (div_q == `DIV8_LAST));

  // fuses are caught during reset so a later change cannot glitch the core
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cks_q <= clock_source_select_fuses_in;
      stime_q <= startup_time_fuses_in;
      div8_q <= divide_by_eight_fuse_in;
    end
  end

  // sequencer and output registers
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q <= ST_POR_CK;
      cnt_q <= 16'h0000;
      div_q <= 3'h0;
      core_rst_q <= 1'b1;
      clk_en_q <= 1'b0;
      wdt_en_q <= 1'b0;
      src_q <= SRC_NONE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      core_rst_q <= rst_d;
      clk_en_q <= clk_en_d;
      wdt_en_q <= wdt_edge;
      src_q <= src_d;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire acc_first = psel_in & penable_in & ~pready_q;
  wire xfer_done = psel_in & penable_in & pready_q;
  wire hit_trim = (paddr_in == `REG_TRIM);
  wire hit_stat = (paddr_in == `REG_STATUS);
  wire hit_nom = (paddr_in == `REG_NOMINAL);
  wire hit_any = hit_trim | hit_stat | hit_nom;
  wire [31:0] stat_word = (32'(run) << `ST_RUN_BIT)
                        | (32'(src_valid) << `ST_VALID_BIT)
                        | (32'(div8_q) << `ST_DIV8_BIT)
                        | (32'(cks_q) << `ST_CKS_LSB)
                        | (32'(stime_q) << `ST_STIME_LSB);
  // nominal frequency in kHz, undivided; external and crystal read zero
  wire [31:0] nom_word = is_rc ? 32'(`RC_NOMINAL_KHZ)
                       : is_o128 ? 32'(`WDT_OSC_KHZ) : 32'h0000_0000;
  wire [31:0] rd_mux = hit_trim ? {24'h00_0000, rc_trim_q}
                     : hit_stat ? stat_word : hit_nom ? nom_word : 32'h0000_0000;
  wire trim_wr = xfer_done & pwrite_in & hit_trim;

  // one wait state: data is registered on the first access cycle
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~hit_any;
      prdata_q <= (acc_first & ~pwrite_in) ? rd_mux : 32'h0000_0000;
    end
  end

  // trim: factory byte on every reset, software value afterwards
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rc_trim_q <= cal_byte_in;
    end else if (trim_wr) begin
      rc_trim_q <= pwdata_in[7:0];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign core_clk_en_out = clk_en_q;
  assign core_rst_out = core_rst_q;
  assign wdt_clk_en_out = wdt_en_q;
  assign rc_trim_out = rc_trim_q;
  assign active_source_out = src_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  sequence s_trim_write;
    psel_in && penable_in && pready_q && pwrite_in && hit_trim;
  endsequence

  sequence s_por_last;
    state_q == ST_POR_CK && src_edge && cnt_q == 16'h000D && stime_q == 2'h0;
  endsequence

  property p_trim_reload;
    $fell(srst_in) |-> rc_trim_out == $past(cal_byte_in);
  endproperty
  a_trim_reload: assert property (p_trim_reload)
    else $error("trim not reloaded from calibration byte");

  property p_trim_write;
    s_trim_write |=> rc_trim_out == $past(pwdata_in[7:0]);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("trim write lost");

  property p_gated;
    state_q != ST_RUN |=> !core_clk_en_out;
  endproperty
  a_gated: assert property (p_gated)
    else $error("core clock enabled before start-up done");

  property p_rc_sel;
    cks_q == 4'h2 && run && rise[`PIN_RC] && !div8_q |=> core_clk_en_out;
  endproperty
  a_rc_sel: assert property (p_rc_sel)
    else $error("RC edge not passed to core");

  property p_lf_sel;
    cks_q == 4'h6 && run && rise[`PIN_LF] && !div8_q |=> core_clk_en_out;
  endproperty
  a_lf_sel: assert property (p_lf_sel)
    else $error("watch crystal edge not passed to core");

  property p_div8;
    run && div8_q && src_edge && div_q != 3'h7 |=> !core_clk_en_out;
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by eight let an extra edge through");

  property p_por_ck;
    s_por_last |=> state_q == ST_RUN && !core_rst_out;
  endproperty
  a_por_ck: assert property (p_por_ck)
    else $error("14 cycle reset delay wrong");

  property p_wake_lf;
    state_q == ST_WAKE && is_lf && !cks_q[0] && cnt_q < 16'h03FF
      |=> state_q == ST_WAKE;
  endproperty
  a_wake_lf: assert property (p_wake_lf)
    else $error("watch crystal wake ended early");

  // long watch crystal wake must not stop at the short count
  property p_wake_lf32;
    state_q == ST_WAKE && is_lf && cks_q[0] && cnt_q < 16'h7FFF
      |=> state_q == ST_WAKE;
  endproperty
  a_wake_lf32: assert property (p_wake_lf32)
    else $error("watch crystal long wake ended early");

  property p_wdt;
    wdt_edge |=> wdt_clk_en_out ##1 !wdt_clk_en_out;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog tick missing");

  property p_ms_done;
    state_q == ST_POR_MS && wdt_edge && ms_last |=> run && !core_rst_out;
  endproperty
  a_ms_done: assert property (p_ms_done)
    else $error("reset time-out did not release core");

endmodule

// ==== shared/clk_startup_defines.svh ====
`ifndef CLK_STARTUP_DEFINES_SVH
`define CLK_STARTUP_DEFINES_SVH

// ----------------------------------------
// clock source select fuse codes
// ----------------------------------------
`define CKS_EXT 4'h0
`define CKS_RC 4'h2
`define CKS_OSC128 4'h3
`define CKS_LF_TOP 2'h1

// ----------------------------------------
// start-up time fuse codes
// ----------------------------------------
`define STIME_SHORT 2'h0
`define STIME_FAST 2'h1

// ----------------------------------------
// timing, in source cycles, in microseconds and in kHz
// ----------------------------------------
`define RESET_CK 16'h000E
`define WAKE_CK_SHORT 16'h0006
`define WAKE_CK_LF1K 16'h0400
`define WAKE_CK_LF32K 16'h8000
`define WDT_OSC_KHZ 128
`define RC_NOMINAL_KHZ 8000
`define DLY_LF_FAST_US 4100
`define DLY_FAST_US 4000
`define DLY_SLOW_US 65000
`define US_TO_TICKS(us) ((((us) * `WDT_OSC_KHZ) + 999) / 1000)
`define DIV8_LAST 3'h7

// ----------------------------------------
// oscillator pin positions in the sync vector
// ----------------------------------------
`define PIN_EXT 0
`define PIN_RC 1
`define PIN_OSC128 2
`define PIN_LF 3
`define PIN_WDT 4
`define NUM_PINS 5

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define REG_TRIM 12'h000
`define REG_STATUS 12'h004
`define REG_NOMINAL 12'h008
`define ST_RUN_BIT 0
`define ST_VALID_BIT 1
`define ST_DIV8_BIT 2
`define ST_CKS_LSB 4
`define ST_STIME_LSB 8

`endif

// ==== shared/clk_startup_pkg.sv ====
package clk_startup_pkg;

  // ----------------------------------------
  // start-up sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POR_CK,
    ST_POR_MS,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } state_t;

  // ----------------------------------------
  // which oscillator feeds the core
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_EXT,
    SRC_RC,
    SRC_OSC128,
    SRC_LFXTAL
  } source_t;

endpackage

// ==== design/osc_edge_sync.sv ====
module osc_edge_sync #(
  parameter int unsigned N = 5
) (
  input wire logic clk_sys_in, // system clock
  input wire logic srst_in, // synchronous reset
  input wire logic [N-1:0] pins_in, // raw oscillator levels
  output logic [N-1:0] rise_out // one pulse per settled rising edge
);

  // ----------------------------------------
  // per-pin three-stage synchroniser
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      logic s1_q; // metastability catcher, read only by s2
      logic s2_q; // second stage
      logic s3_q; // third stage
      logic stable_q; // last level seen on both s2 and s3
      logic rise_q; // registered edge pulse
      wire agree = (s2_q == s3_q);
      // a change counts only once stages two and three agree
      always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          stable_q <= 1'b0;
          rise_q <= 1'b0;
        end else begin
          s1_q <= pins_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          stable_q <= agree ? s3_q : stable_q;
          rise_q <= agree & s3_q & ~stable_q;
        end
      end
      assign rise_out[i] = rise_q;
    end
  endgenerate

endmodule

// ==== test/osc_sources.sv ====
// free-running oscillator models facing the clock block
module osc_sources #(
  parameter int H_EXT = 48, // half periods in ns, each at least 3 system cycles
  parameter int H_RC = 32,
  parameter int H_128 = 40,
  parameter int H_LF = 24,
  parameter int H_WDT = 24
) (
  output logic ext_out, // external clock source
  output logic rc_out, // internal rc oscillator
  output logic o128_out, // 128 kHz oscillator, scaled
  output logic lf_out, // watch crystal, scaled
  output logic wdt_out // watchdog oscillator
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // oscillators
  // ----------------------------------------
  // periods are scaled down so start-up counts fit a short run
  initial begin
    ext_out = 1'b0;
    rc_out = 1'b1;
    o128_out = 1'b0;
    lf_out = 1'b1;
    wdt_out = 1'b0;
  end
  always #(H_EXT) ext_out = ~ext_out;
  always #(H_RC) rc_out = ~rc_out;
  always #(H_128) o128_out = ~o128_out;
  always #(H_LF) lf_out = ~lf_out;
  // watchdog runs from its own source, never the 128 kHz one
  // same period as the crystal model but in antiphase, so tick counts stay exact
  always #(H_WDT) wdt_out = ~wdt_out;
endmodule

// ==== test/clock_source_startup_select_tb.sv ====
module clock_source_startup_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_startup_pkg::*;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  localparam int SLOW = 20; // shortened long delay, watchdog ticks
  localparam int PW = 6; // watchdog period, system cycles (exact)
  logic clk_sys_in = 1'b0, srst_in = 1'b1, div8 = 1'b0, sleep_req = 1'b0, wake_req = 1'b0;
  logic [3:0] cks = 4'h2;
  logic [1:0] stime = 2'h0;
  logic [7:0] cal = 8'hA5;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000_09D2, r;
  logic pready, pslverr, core_en, core_rst, wdt_en;
  logic [7:0] trim;
  source_t act;
  wire ext_p, rc_p, o128_p, lf_p, wdt_p;
  logic [33:0] exp_q[$]; // {check data, error, data}
  logic [33:0] e_now;
  int err_total = 0, samples_checked = 0, cyc = 0, t, n;
  int p_tab[4] = '{12, 8, 10, 6};
  logic [3:0] c_tab[4] = '{4'h0, 4'h2, 4'h3, 4'h6};
  source_t s_tab[4] = '{SRC_EXT, SRC_RC, SRC_OSC128, SRC_LFXTAL};
  logic [31:0] nom_tab[4] = '{32'h0, 32'h1F40, 32'h80, 32'h0};
  int d_code[4] = '{2, 2, 6, 3}, d_stime[4] = '{1, 2, 1, 3}, d_p[4] = '{8, 8, 6, 10};
  int d_x[4] = '{512, SLOW, 525, SLOW};

  always #4 clk_sys_in = ~clk_sys_in;

  osc_sources osc (.ext_out(ext_p), .rc_out(rc_p), .o128_out(o128_p), .lf_out(lf_p),
    .wdt_out(wdt_p));

  clock_source_startup_select #(.SLOW_DLY_TICKS(SLOW)) dut (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .clock_source_select_fuses_in(cks),
    .startup_time_fuses_in(stime), .divide_by_eight_fuse_in(div8), .cal_byte_in(cal),
    .external_clock_input_in(ext_p), .rc_osc_clk_in(rc_p), .osc128_clk_in(o128_p),
    .timer_osc_pin_one_in(lf_p), .wdt_osc_clk_in(wdt_p), .sleep_req_in(sleep_req),
    .wake_req_in(wake_req), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .core_clk_en_out(core_en), .core_rst_out(core_rst),
    .wdt_clk_en_out(wdt_en), .rc_trim_out(trim), .active_source_out(act));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic win(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  task automatic close_out();
    $display("compared %0d, mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; expectation is queued for the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    // no wait count assumed; only the run timeout ends a stuck transfer
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // fuses are latched in reset; returns cycles from release to core run
  task automatic do_reset(input logic [3:0] c, input logic [1:0] s, input logic dv);
    @(posedge clk_sys_in);
    r = rnd();
    cks <= c;
    stime <= s;
    div8 <= dv;
    cal <= r[7:0];
    srst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check({31'h0, core_rst}, 32'h1);
    srst_in <= 1'b0;
    t = 0;
    do begin
      @(posedge clk_sys_in);
      t++;
    end while (core_rst !== 1'b0 && t < 20000);
  endtask

  task automatic pulses(input int cycles, input bit w);
    n = 0;
    repeat (cycles) begin
      @(posedge clk_sys_in);
      if ((w ? wdt_en : core_en) === 1'b1) n++;
    end
  endtask

  task automatic sleep_wake(input int p, input int ck);
    @(posedge clk_sys_in) sleep_req <= 1'b1;
    @(posedge clk_sys_in) sleep_req <= 1'b0;
    // the edge that takes the sleep request may still launch one last pulse
    @(posedge clk_sys_in);
    pulses(100, 0);
    check(n, 0);
    @(posedge clk_sys_in) wake_req <= 1'b1;
    @(posedge clk_sys_in) wake_req <= 1'b0;
    t = 0;
    do begin
      @(posedge clk_sys_in);
      t++;
    end while (core_en !== 1'b1 && t < 20000);
    win(t, (ck - 1) * p, ck * p + 12);
  endtask

  // ----------------------------------------
  // result monitor and hang guard
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      e_now = exp_q.pop_front();
      if (e_now[33]) check(prdata, e_now[31:0]);
      check({31'h0, pslverr}, {31'h0, e_now[32]});
    end
  end

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(c_tab[i], 2'h0, 1'b0);
      win(t, 13 * p_tab[i], 14 * p_tab[i] + 10);
      check({29'h0, act}, {29'h0, s_tab[i]});
      check(trim, cal);
      pulses(40 * p_tab[i], 0);
      win(n, 39, 41);
      apb(1'b0, 12'h008, 32'h0, {2'b10, nom_tab[i]});
      apb(1'b0, 12'h004, 32'h0, {2'b10, 22'h0, 2'h0, c_tab[i], 4'h3});
    end
    $display("source selection done");
    for (int i = 0; i < 4; i++) begin
      do_reset(d_code[i][3:0], d_stime[i][1:0], 1'b0);
      win(t, 13 * d_p[i] + (d_x[i] - 1) * PW, 14 * d_p[i] + (d_x[i] + 1) * PW + 12);
    end
    $display("reset delays done");
    do_reset(4'h0, 2'h0, 1'b1);
    pulses(80 * 12, 0);
    win(n, 9, 11);
    apb(1'b0, 12'h004, 32'h0, {2'b10, 22'h0, 2'h0, 4'h0, 4'h7});
    pulses(60 * PW, 1);
    win(n, 50, 61);
    $display("divider and watchdog done");
    do_reset(4'h2, 2'h0, 1'b0);
    sleep_wake(8, 6);
    do_reset(4'h6, 2'h0, 1'b0);
    sleep_wake(6, 1024);
    // long crystal wake: still dark well past the short count
    do_reset(4'h7, 2'h0, 1'b0);
    check({29'h0, act}, {29'h0, SRC_LFXTAL});
    @(posedge clk_sys_in) sleep_req <= 1'b1;
    @(posedge clk_sys_in) sleep_req <= 1'b0;
    @(posedge clk_sys_in) wake_req <= 1'b1;
    @(posedge clk_sys_in) wake_req <= 1'b0;
    pulses(1100 * 6, 0);
    check(n, 0);
    $display("sleep and wake done");
    apb(1'b0, 12'h000, 32'h0, {2'b10, 24'h0, cal});
    r = rnd();
    apb(1'b1, 12'h000, r, 34'h0);
    apb(1'b0, 12'h000, 32'h0, {2'b10, 24'h0, r[7:0]});
    check(trim, r[7:0]);
    apb(1'b1, 12'h004, 32'h0, 34'h0);
    apb(1'b0, 12'h00C, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h010, r, {2'b01, 32'h0});
    do_reset(4'h2, 2'h0, 1'b0);
    check(trim, cal);
    $display("registers done");
    check(exp_q.size(), 0);
    close_out();
  end
endmodule
